// ### src/sfi_spi_fram_regs.vh
// Constants for the serial ferroelectric memory slave front end
`ifndef SFI_SPI_FRAM_REGS_VH
`define SFI_SPI_FRAM_REGS_VH

// Operation codes, most significant bit first on the wire
`define SFI_OP_LATCH_SET    8'h06
`define SFI_OP_LATCH_CLEAR  8'h04
`define SFI_OP_STATUS_READ  8'h05
`define SFI_OP_STATUS_WRITE 8'h01
`define SFI_OP_MEM_READ     8'h03
`define SFI_OP_MEM_WRITE    8'h02

// Array geometry
`define SFI_ADDR_W          15
`define SFI_BYTE_W          8
`define SFI_BIT_CNT_W       3
`define SFI_BIT_LAST        3'h7

// Status byte layout
`define SFI_SR_WEL_BIT      1
`define SFI_SR_WR_MASK      8'h8C
`define SFI_SR_RST          8'h00

// Synchroniser reset pattern {cs_n, sck, si, hold_n, wp_n}
`define SFI_SYNC_W          5
`define SFI_SYNC_RST        5'h13
`define SFI_SYNC_CS_BIT     4
`define SFI_SYNC_SCK_BIT    3
`define SFI_SYNC_SI_BIT     2
`define SFI_SYNC_HOLD_BIT   1
`define SFI_SYNC_WP_BIT     0

// Highest serial clock rate the interface accepts
`define SFI_SCK_MAX_MHZ     20

`endif

// ### src/sfi_spi_fram.v
// Serial ferroelectric memory slave front end with its byte array
`timescale 1ns/100ps
// How it works
// - Chip select high: standby, inputs ignored, outputs off
// - Serial clock only honoured while selected
// - Capture on rising edge, shift out on falling
// - Static link, clock may stop anywhere
// - Suspend low freezes operation, ignores clock, select
// - Write protect low blocks status writes only
// - Serial input sampled on rising edges only
// - Output driven only while returning read data
// - Array holds 32768 bytes, 15-bit address
// - Opcode, two address bytes, top bit ignored
// - Each write byte committed once fully received while the write permit flag is set
// - No busy state, next transaction accepted immediately
// - Clock modes 0 and 3 only
// - Six opcodes decoded by their fixed codes
// - One opcode per select, then deselect
// - Bytes of eight bits, most significant first
// - Write permit flag: reset clear, set, cleared
`include "sfi_spi_fram_regs.vh"

module sfi_spi_fram #(
  parameter ADDR_W = `SFI_ADDR_W,
  parameter BYTE_W = `SFI_BYTE_W
) (
  input  wire i_clk,
  input  wire i_rst,
  input  wire i_cs_n,
  input  wire i_sck,
  input  wire i_si,
  input  wire i_hold_n,
  input  wire i_wp_n,
  output reg  o_so,
  output reg  o_so_oe,
  output reg  o_standby
);

  // One-hot transaction phases
  localparam [7:0] ST_OPC  = 8'h01; // Waiting for the opcode byte
  localparam [7:0] ST_ADH  = 8'h02; // Upper address byte
  localparam [7:0] ST_ADL  = 8'h04; // Lower address byte
  localparam [7:0] ST_WDAT = 8'h08; // Memory write data
  localparam [7:0] ST_RDAT = 8'h10; // Memory read data
  localparam [7:0] ST_SRD  = 8'h20; // Status byte out
  localparam [7:0] ST_SWR  = 8'h40; // Status byte in
  localparam [7:0] ST_IGN  = 8'h80; // Rest of frame ignored

  // Next address with wrap from the top location to zero
  function [ADDR_W-1:0] addr_inc;
    input [ADDR_W-1:0] a;
    begin
      addr_inc = a + {{(ADDR_W-1){1'b0}}, 1'b1};
    end
  endfunction

  // Byte array, no reset
  reg [BYTE_W-1:0] mem [0:(1<<ADDR_W)-1];

  reg [`SFI_SYNC_W-1:0]    sync1_q;
  reg [`SFI_SYNC_W-1:0]    sync2_q;
  reg                      sck_s3_q;
  reg                      cs_eff_q;
  reg [7:0]                state_q;
  reg [`SFI_BIT_CNT_W-1:0] cnt_q;
  reg [BYTE_W-1:0]         shift_q;
  reg [BYTE_W-1:0]         tx_q;
  reg [BYTE_W-1:0]         rd_byte_q;
  reg [ADDR_W-1:0]         addr_q;
  reg [BYTE_W-1:0]         status_q;
  reg                      wel_q;
  reg                      wrote_q;
  reg                      wr_req_q;
  reg                      started_q;

  wire             cs_s    = sync2_q[`SFI_SYNC_CS_BIT];
  wire             sck_s   = sync2_q[`SFI_SYNC_SCK_BIT];
  wire             si_s    = sync2_q[`SFI_SYNC_SI_BIT];
  wire             hold_s  = sync2_q[`SFI_SYNC_HOLD_BIT];
  wire             wp_s    = sync2_q[`SFI_SYNC_WP_BIT];
  wire             sck_ris = sck_s & ~sck_s3_q;
  wire             sck_fal = ~sck_s & sck_s3_q;
  wire             active;
  wire             desel;
  wire             byte_end;
  wire             out_ph;
  wire [BYTE_W-1:0] rx;
  wire [BYTE_W-1:0] status_view;
  wire [ADDR_W-1:0] addr_new;
  wire             mem_we;

  // Selected, not suspended, and select not rising this cycle
  assign active   = hold_s & ~cs_eff_q & ~cs_s;
  // Deselect seen only while not suspended
  assign desel    = hold_s & cs_s & ~cs_eff_q;
  assign byte_end = (cnt_q == `SFI_BIT_LAST);
  assign out_ph   = (state_q == ST_RDAT) | (state_q == ST_SRD);
  // Incoming byte, most significant bit first
  assign rx       = {shift_q[BYTE_W-2:0], si_s};
  // Upper bits held from the first address byte, low byte just shifted in
  assign addr_new = {addr_q[ADDR_W-1:BYTE_W], rx};
  // Status byte as read, flag bit inserted
  assign status_view = (status_q & `SFI_SR_WR_MASK) |
                       ({{(BYTE_W-1){1'b0}}, wel_q} << `SFI_SR_WEL_BIT);
  // Array write strobe on the last bit of each data byte while the write permit flag is set
  assign mem_we   = active & sck_ris & byte_end &
                    (state_q == ST_WDAT) & wel_q;

  // Two-stage synchroniser on every pin, then sck edge history
  always @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      sync1_q  <= `SFI_SYNC_RST;
      sync2_q  <= `SFI_SYNC_RST;
      sck_s3_q <= 1'b0;
    end
    else
    begin
      sync1_q  <= {i_cs_n, i_sck, i_si, i_hold_n, i_wp_n};
      sync2_q  <= sync1_q;
      sck_s3_q <= sck_s;
    end
  end

  // Array write, committed without delay
  always @(posedge i_clk)
  begin
    if (mem_we)
      mem[addr_q] <= rx;
  end

  // Transaction engine
  always @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      cs_eff_q  <= 1'b1;
      state_q   <= ST_OPC;
      cnt_q     <= {`SFI_BIT_CNT_W{1'b0}};
      shift_q   <= {BYTE_W{1'b0}};
      tx_q      <= {BYTE_W{1'b0}};
      rd_byte_q <= {BYTE_W{1'b0}};
      addr_q    <= {ADDR_W{1'b0}};
      status_q  <= `SFI_SR_RST;
      wel_q     <= 1'b0;
      wrote_q   <= 1'b0;
      wr_req_q  <= 1'b0;
      started_q <= 1'b0;
      o_so      <= 1'b0;
      o_so_oe   <= 1'b0;
      o_standby <= 1'b1;
    end
    else
    begin
      // Select level frozen while suspended
      if (hold_s)
        cs_eff_q <= cs_s;
      // Drive only in a read phase, never when suspended or deselected
      o_so_oe   <= hold_s & ~cs_eff_q & ~cs_s & out_ph
                   & started_q;
      o_standby <= cs_eff_q;
      if (desel)
      begin
        // Frame over: back to opcode, finish any write
        state_q   <= ST_OPC;
        cnt_q     <= {`SFI_BIT_CNT_W{1'b0}};
        started_q <= 1'b0;
        wrote_q   <= 1'b0;
        if (wrote_q)
          wel_q <= 1'b0;
      end
      else if (active & sck_ris)
      begin
        // Capture on the rising edge only
        shift_q <= rx;
        cnt_q   <= cnt_q + {{(`SFI_BIT_CNT_W-1){1'b0}}, 1'b1};
        if (byte_end)
        begin
          case (state_q)
            ST_OPC:
            begin
              // Opcode decode
              case (rx)
                `SFI_OP_LATCH_SET:
                begin
                  wel_q   <= 1'b1;
                  state_q <= ST_IGN;
                end
                `SFI_OP_LATCH_CLEAR:
                begin
                  wel_q   <= 1'b0;
                  state_q <= ST_IGN;
                end
                `SFI_OP_STATUS_READ:
                begin
                  rd_byte_q <= status_view;
                  state_q   <= ST_SRD;
                end
                `SFI_OP_STATUS_WRITE:
                  state_q <= ST_SWR;
                `SFI_OP_MEM_READ:
                begin
                  wr_req_q <= 1'b0;
                  state_q  <= ST_ADH;
                end
                `SFI_OP_MEM_WRITE:
                begin
                  wr_req_q <= 1'b1;
                  state_q  <= ST_ADH;
                end
                default:
                  state_q <= ST_IGN;
              endcase
            end
            ST_ADH:
            begin
              // Keep the upper address bits, top bit of the pair dropped
              addr_q  <= {rx[ADDR_W-BYTE_W-1:0], {BYTE_W{1'b0}}};
              state_q <= ST_ADL;
            end
            ST_ADL:
            begin
              if (wr_req_q)
              begin
                addr_q  <= addr_new;
                state_q <= ST_WDAT;
              end
              else
              begin
                // Prefetch first read byte
                rd_byte_q <= mem[addr_new];
                addr_q    <= addr_inc(addr_new);
                state_q   <= ST_RDAT;
              end
            end
            ST_WDAT:
            begin
              if (wel_q)
                wrote_q <= 1'b1;
              addr_q <= addr_inc(addr_q);
            end
            ST_RDAT:
            begin
              rd_byte_q <= mem[addr_q];
              addr_q    <= addr_inc(addr_q);
            end
            ST_SRD:
              rd_byte_q <= status_view;
            ST_SWR:
            begin
              // Protect pin blocks the status write only
              if (wel_q & wp_s)
                status_q <= rx & `SFI_SR_WR_MASK;
              if (wel_q)
                wrote_q <= 1'b1;
              state_q <= ST_IGN;
            end
            ST_IGN:
              state_q <= ST_IGN;
            default:
              state_q <= ST_IGN;
          endcase
        end
      end
      else if (active & sck_fal & out_ph)
      begin
        // Output changes on the falling edge only
        started_q <= 1'b1;
        if (cnt_q == {`SFI_BIT_CNT_W{1'b0}})
        begin
          o_so <= rd_byte_q[BYTE_W-1];
          tx_q <= {rd_byte_q[BYTE_W-2:0], 1'b0};
        end
        else
        begin
          o_so <= tx_q[BYTE_W-1];
          tx_q <= {tx_q[BYTE_W-2:0], 1'b0};
        end
      end
    end
  end

endmodule // sfi_spi_fram

// ### bench/sfi_spi_fram_props.sv
// Port property checker for the serial memory front end
`timescale 1ns/100ps
module sfi_spi_fram_props (
  input wire i_clk,
  input wire i_rst,
  input wire i_cs_n,
  input wire i_sck,
  input wire i_hold_n,
  input wire o_so,
  input wire o_so_oe,
  input wire o_standby
);
  default clocking @(posedge i_clk);
  endclocking
  default disable iff (i_rst);
  // Output released and frozen outside active transfers, shifted on falling clock, enabled within a frame; standby follows select
  a_desel_off: assert property (i_cs_n [*7] |-> !o_so_oe)
    else $error("output on while deselected");
  a_hold_still: assert property (
    !i_hold_n [*8] |-> !o_so_oe && $stable(o_so))
    else $error("output moved in suspend");
  a_idle_still: assert property (i_cs_n [*8] |-> $stable(o_so))
    else $error("output moved while deselected");
  a_fall_shift: assert property (
    o_so_oe && $changed(o_so) |-> $past(i_sck, 5) && !$past(i_sck, 2))
    else $error("output changed off a falling clock");
  a_oe_framed: assert property (
    $rose(o_so_oe) |-> !i_cs_n && !$past(i_cs_n, 6))
    else $error("output enabled outside a frame");
  a_standby_on: assert property (
    (i_cs_n && i_hold_n) [*6] |-> o_standby)
    else $error("no standby when deselected");
  a_active_on: assert property (
    (!i_cs_n && i_hold_n) [*6] |-> !o_standby)
    else $error("standby while selected");
  a_standby_lag: assert property (
    $changed(o_standby) |-> o_standby == $past(i_cs_n, 2))
    else $error("standby out of step with select");
endmodule // sfi_spi_fram_props

bind sfi_spi_fram sfi_spi_fram_props u_props (.i_clk(i_clk), .i_rst(i_rst),
  .i_cs_n(i_cs_n), .i_sck(i_sck), .i_hold_n(i_hold_n), .o_so(o_so),
  .o_so_oe(o_so_oe), .o_standby(o_standby));

// ### bench/sfi_host_model.sv
// Host controller model driving the serial memory link
`timescale 1ns/100ps
module sfi_host_model (
  input  wire i_clk,
  input  wire i_so,
  input  wire i_so_oe,
  output reg  o_cs_n,
  output reg  o_sck,
  output reg  o_si,
  output reg  o_hold_n
);
  reg  last_q;
  wire line = i_so_oe ? i_so : ~last_q; // Released line never repeats
  // Deselected from power up
  initial
  begin
    o_cs_n = 1'h1;
    o_sck = 1'h0;
    o_si = 1'h0;
    o_hold_n = 1'h1;
    last_q = 1'h0;
  end
  // Last level the device drove
  always @(posedge i_clk)
    if (i_so_oe)
      last_q <= i_so;
  task w(input integer n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  // Select; mode 3 idles the clock high
  task sel(input m3);
    o_sck = m3;
    w(4);
    o_cs_n = 1'h0;
    w(4);
    o_sck = 1'h0;
  endtask
  // One byte each way, top bit first, 800 ns clock
  task xb(input [7:0] tx, output [7:0] rx);
    integer i;
    for (i = 7; i >= 0; i = i - 1)
    begin
      o_si = tx[i];
      w(4);
      o_sck = 1'h1;
      rx[i] = line;
      w(4);
      o_sck = 1'h0;
    end
  endtask
  // Release select first so no extra rising edge lands in the frame
  task desel(input m3);
    w(4);
    o_cs_n = 1'h1;
    w(4);
    o_sck = m3;
    w(4);
  endtask
  // Suspend with clock and select pulses that must be ignored
  task pause;
    integer i;
    w(4);
    o_hold_n = 1'h0;
    for (i = 0; i < 4; i = i + 1)
    begin
      w(4);
      o_sck = ~o_sck;
      o_cs_n = (i == 1);
    end
    w(4);
    o_hold_n = 1'h1;
    w(4);
  endtask
endmodule // sfi_host_model

// ### bench/sfi_spi_fram_tb.sv
// Self-checking bench for the serial memory front end
`timescale 1ns/100ps
`include "sfi_spi_fram_regs.vh"
module sfi_spi_fram_tb;
  reg         clk = 1'h0;
  reg         rst = 1'h1;
  reg         wp_n = 1'h1;
  reg         ps = 1'h0;
  wire        cs_n;
  wire        sck;
  wire        si;
  wire        hold_n;
  wire        so;
  wire        so_oe;
  integer     errors = 0;
  integer     check_count = 0;
  integer     cyc = 0;
  integer     i;
  integer     n;
  reg  [7:0]  b;
  reg  [14:0] a;
  reg  [15:0] ra;
  reg  [7:0]  dq [0:7];
  reg  [7:0]  rq [0:7];
  reg  [7:0]  ex [0:32767];
  always #50 clk = ~clk;
  sfi_spi_fram dut (.i_clk(clk), .i_rst(rst), .i_cs_n(cs_n), .i_sck(sck),
    .i_si(si), .i_hold_n(hold_n), .i_wp_n(wp_n), .o_so(so),
    .o_so_oe(so_oe), .o_standby());
  sfi_host_model h (.i_clk(clk), .i_so(so), .i_so_oe(so_oe), .o_cs_n(cs_n),
    .o_sck(sck), .o_si(si), .o_hold_n(hold_n));
  function [7:0] sr_exp(input f, input [7:0] st);
    sr_exp = (st & `SFI_SR_WR_MASK) | {6'h00, f, 1'h0};
  endfunction
  task chk(input [7:0] got, input [7:0] exp);
    check_count = check_count + 1;
    if (got !== exp)
    begin
      errors = errors + 1;
      $display("CHECK FAILED %0t got %h want %h", $time, got, exp);
    end
  endtask
  task give_verdict;
    if (errors == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Hang guard
  always @(posedge clk)
  begin
    cyc = cyc + 1;
    if (cyc == 25000)
    begin
      errors = errors + 1;
      $display("CHECK FAILED %0t timeout", $time);
      give_verdict;
    end
  end
  // Opcode, address for memory codes, then n data bytes
  task frame(input [7:0] op, input [15:0] ad, input integer m, input m3);
    integer k;
    h.sel(m3);
    h.xb(op, b);
    if (op == `SFI_OP_MEM_READ || op == `SFI_OP_MEM_WRITE)
    begin
      h.xb(ad[15:8], b);
      h.xb(ad[7:0], b);
    end
    for (k = 0; k < m; k = k + 1)
    begin
      if (k == 1 && ps)
        h.pause;
      h.xb(dq[k], rq[k]);
    end
    h.desel(m3);
  endtask
  task status(input f, input [7:0] st);
    frame(`SFI_OP_STATUS_READ, 16'h0000, 1, 1'h0);
    chk(rq[0], sr_exp(f, st));
  endtask
  task wr(input [15:0] ad, input integer m, input en);
    integer k;
    if (en)
      frame(`SFI_OP_LATCH_SET, 16'h0000, 0, 1'h0);
    for (k = 0; k < m; k = k + 1)
      dq[k] = 8'($urandom);
    frame(`SFI_OP_MEM_WRITE, ad, m, 1'h0);
    for (k = 0; k < m; k = k + 1)
    begin
      a = ad[14:0] + 15'(k);
      if (en)
        ex[a] = dq[k];
    end
  endtask
  task rd(input [15:0] ad, input integer m, input m3);
    integer k;
    frame(`SFI_OP_MEM_READ, ad, m, m3);
    for (k = 0; k < m; k = k + 1)
    begin
      a = ad[14:0] + 15'(k);
      chk(rq[k], ex[a]);
    end
  endtask
  // Main sequence
  initial
  begin
    void'($urandom(32'hA288));
    repeat (16) @(posedge clk);
    #1;
    rst = 1'h0;
    h.w(4);
    status(1'h0, 8'h00);
    frame(`SFI_OP_LATCH_SET, 16'h0000, 0, 1'h0);
    status(1'h1, 8'h00);
    frame(`SFI_OP_LATCH_CLEAR, 16'h0000, 0, 1'h0);
    status(1'h0, 8'h00);
    dq[0] = 8'hFF;
    for (i = 0; i < 2; i = i + 1)
    begin
      wp_n = i[0];
      frame(`SFI_OP_LATCH_SET, 16'h0000, 0, 1'h0);
      frame(`SFI_OP_STATUS_WRITE, 16'h0000, 1, 1'h0);
      status(1'h0, i[0] ? 8'hFF : 8'h00);
    end
    wr(16'hFFFE, 4, 1'h1);
    rd(16'h7FFE, 4, 1'h0);
    // Same low byte, other upper bits: 0001 must not alias, C001 drops its top bit and maps onto 4001
    wr(16'h4001, 1, 1'h1);
    rd(16'h0001, 1, 1'h0);
    rd(16'hC001, 1, 1'h1);
    wr(16'h8000, 1, 1'h0);
    rd(16'h0000, 1, 1'h0);
    for (i = 0; i < 8; i = i + 1)
    begin
      ra = 16'($urandom);
      n = 2 + $urandom % 3;
      wr(ra, n, 1'h1);
      ps = i[0];
      rd(ra, n, i[1]);
      ps = 1'h0;
    end
    give_verdict;
  end
endmodule // sfi_spi_fram_tb
